// >>> inc/mon_pkg.sv
// constants and types shared by the monitor serial port
package mon_pkg;
  localparam int             BIT_W         = 11;
  localparam int             DIV_HI        = 1024;
  localparam int             DIV_LO        = 512;
  localparam logic [1:0]     BUS_LIM_HI    = 2'h3;
  localparam logic [1:0]     BUS_LIM_LO    = 2'h1;
  localparam logic [15:0]    VEC_RST_USER  = 16'hFFFE;
  localparam logic [15:0]    VEC_SWI_USER  = 16'hFFFC;
  localparam logic [15:0]    VEC_RST_MON   = 16'hFEFE;
  localparam logic [15:0]    VEC_SWI_MON   = 16'hFEFC;
  localparam logic [15:0]    SEC_BASE      = 16'hFFF6;
  localparam logic [2:0]     SEC_LAST      = 3'h7;
  localparam logic [15:0]    SEC_FLAG_ADDR = 16'h0060;
  localparam logic [7:0]     SEC_FLAG_MASK = 8'h40;
  localparam logic [15:0]    FLASH_BASE    = 16'h8000;
  localparam logic [7:0]     FLASH_INVALID = 8'h00;
  localparam logic [7:0]     OP_READ       = 8'h41;
  localparam logic [7:0]     OP_WRITE      = 8'h42;
  localparam logic [7:0]     OP_INDEXED_READ_CMD      = 8'h43;
  localparam logic [7:0]     OP_INDEXED_WRITE_CMD     = 8'h44;
  localparam logic [7:0]     OP_STACK_POINTER_READ_CMD     = 8'h0C;
  localparam logic [7:0]     OP_RUN        = 8'h45;
  localparam logic [2:0]     LEN_READ      = 3'h3;
  localparam logic [2:0]     LEN_WRITE     = 3'h4;
  localparam logic [2:0]     LEN_INDEXED_WRITE_CMD    = 3'h2;
  localparam logic [2:0]     LEN_ONE       = 3'h1;
  localparam logic [3:0]     GAP_BITS      = 4'h2;
  localparam logic [3:0]     WAIT_BITS     = 4'hB;
  localparam logic [3:0]     FRAME_BITS    = 4'hA;
  localparam logic [3:0]     LAST_SAMPLE   = 4'h9;
  typedef enum logic [1:0] {
    TX_BYTE,
    TX_BREAK,
    TX_HIGH,
    TX_WAIT
  } tx_kind_t;
endpackage

// >>> design/mon_serial_phy.sv
// half-duplex bit engine for the single monitor serial pin
`timescale 1ns/1ps
`default_nettype none
module mon_serial_phy
  import mon_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [BIT_W-1:0] bit_cycles,
  input  wire logic             rx_pin,
  input  wire logic             tx_go,
  input  wire tx_kind_t         tx_kind,
  input  wire logic [3:0]       tx_bits,
  input  wire logic [7:0]       tx_byte,
  output logic                  tx_out,
  output logic                  tx_oe,
  output logic                  tx_done,
  output logic                  rx_valid,
  output logic                  rx_break,
  output logic [7:0]            rx_data
);
  typedef struct packed {
    logic             toe;
    logic             tout;
    logic             tdone;
    logic [BIT_W-1:0] tcnt;
    logic [3:0]       tleft;
    logic [9:0]       tsh;
    logic             ract;
    logic             rhold;
    logic [BIT_W-1:0] rcnt;
    logic [3:0]       ridx;
    logic [9:0]       rsh;
    logic             rvalid;
    logic             rbrk;
    logic [7:0]       rdata;
  } phy_t;
  phy_t q;
  phy_t n;
  logic [9:0] smp;

  always_comb
  begin
    n = q;
    n.tdone = 1'b0;
    n.rvalid = 1'b0;
    n.rbrk = 1'b0;
    smp = {rx_pin, q.rsh[9:1]};
    if (tx_go)
    begin
      n.tcnt = bit_cycles - 1'b1;
      n.toe = (tx_kind != TX_WAIT);
      unique case (tx_kind)
        TX_BYTE:  n.tsh = {1'b1, tx_byte, 1'b0}; // see [RULE24] [RULE3]
        TX_BREAK: n.tsh = '0;
        TX_HIGH:  n.tsh = '1;
        TX_WAIT:  n.tsh = '1;
      endcase
      n.tleft = (tx_kind == TX_BYTE || tx_kind == TX_BREAK) ?
                FRAME_BITS : tx_bits;
      n.tout = n.tsh[0];
    end
    else if (q.tleft != '0)
    begin
      if (q.tcnt == '0)
      begin
        n.tleft = q.tleft - 1'b1;
        n.tsh = {1'b1, q.tsh[9:1]};
        n.tcnt = bit_cycles - 1'b1;
        n.tout = n.tsh[0];
        if (q.tleft == 4'h1)
        begin
          n.tdone = 1'b1;
          n.toe = 1'b0; // see [RULE25]
          n.tout = 1'b1;
        end
      end
      else
        n.tcnt = q.tcnt - 1'b1;
    end
    // our own transmission is never taken as received data
    if (q.toe)
    begin
      n.ract = 1'b0;
      n.rhold = 1'b1; // see [RULE25]
    end
    else if (q.rhold)
      n.rhold = !rx_pin;
    else if (!q.ract)
    begin
      if (!rx_pin)
      begin
        n.ract = 1'b1;
        n.rcnt = bit_cycles >> 1;
        n.ridx = '0;
      end
    end
    else if (q.rcnt == '0)
    begin
      n.rsh = smp;
      n.rcnt = bit_cycles - 1'b1;
      n.ridx = q.ridx + 1'b1;
      if (q.ridx == LAST_SAMPLE)
      begin
        n.ract = 1'b0;
        n.rhold = 1'b1;
        n.rdata = smp[8:1];
        if (smp == '0)
          n.rbrk = 1'b1; // see [RULE4]
        else if (smp[9])
          n.rvalid = 1'b1; // see [RULE24]
      end
    end
    else
      n.rcnt = q.rcnt - 1'b1;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.tout <= 1'b1;
      q.rhold <= 1'b1;
    end
    else
      q <= n;
  end

  assign tx_out = q.tout;
  assign tx_oe = q.toe;
  assign tx_done = q.tdone;
  assign rx_valid = q.rvalid;
  assign rx_break = q.rbrk;
  assign rx_data = q.rdata;
endmodule
`default_nettype wire

// >>> design/monitor_serial_command_port.sv
// monitor mode serial command port: entry, security, command engine
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] blank-vector monitor entry is left only by power-on reset
// [RULE2] monitor mode uses vectors at FEFE/FEFF and FEFC/FEFD
// [RULE3] NRZ mark/space bytes, host sends at the device's baud rate
// [RULE4] start bit plus nine more low bits is a break
// [RULE5] received break: drive pin high two bits, then send break
// [RULE6] high-voltage entry: bit period is osc/1024 or osc/512 by select pin
// [RULE7] blank-vector low-voltage entry always uses divide by 1024
// [RULE8] bus clock 2.4576 MHz and 9600 baud, scaling with oscillator
// [RULE9] every received byte is echoed back
// [RULE10] wait eleven bits after each command; break cancels it
// [RULE11] two-bit gap before each echo and before returned read data
// [RULE12] host waits one bit after each echo before next byte
// [RULE13] indexed reads and writes step through consecutive addresses
// [RULE14] opcode 0C returns stack pointer plus one, high byte first
// [RULE15] entry stacks registers; run pops high index and returns
// [RULE16] eight security bytes after power-on compared with FFF6..FFFD
// [RULE17] passed security persists across all but power-on reset
// [RULE18] failed security: invalid flash reads, flash fetch resets
// [RULE19] ready break is sent only after all eight security bytes
// [RULE20] correct security sets bit 6 of RAM address 60
// [RULE21] mass erase leaves security bytes reading FF
// [RULE22] after failed security host should power-cycle and retry
// [RULE23] monitor selection latched on rising edge of external reset
// [RULE24] frame: low start, eight data bits LSB first, high stop
// [RULE25] one shared pin; each side releases it while other sends
module monitor_serial_command_port
  import mon_pkg::*;
#(
  parameter int DIV_HI_P = DIV_HI,
  parameter int DIV_LO_P = DIV_LO
)
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        monitor_serial_pin_in,
  output logic             monitor_serial_pin_out,
  output logic             monitor_serial_pin_oe,
  input  wire logic        divider_select_pin,
  input  wire logic        entry_voltage_pin_hv,
  input  wire logic        ext_reset_n,
  input  wire logic        reset_vector_blank,
  input  wire logic [15:0] stack_pointer,
  input  wire logic        cpu_fetch_flash,
  input  wire logic [7:0]  mem_rdata,
  output logic [15:0]      mem_addr,
  output logic [7:0]       mem_wdata,
  output logic             mem_we,
  output logic             mem_re,
  output logic             monitor_mode,
  output logic             security_ok,
  output logic             bus_clk_en,
  output logic [15:0]      vec_reset_addr,
  output logic [15:0]      vec_swi_addr,
  output logic             stack_entry_req,
  output logic             run_req,
  output logic             illegal_addr_reset
);
  typedef enum logic [4:0] {
    S_OFF, S_SEC_RX, S_SEC_CMP, S_FLAG_RD, S_RDY_BRK, S_CMD_RX,
    S_ECHO_GAP, S_ECHO, S_DISPATCH, S_FETCH, S_DATA_GAP, S_DATA_TX,
    S_WAIT11, S_EXEC, S_BRK_GAP, S_BRK_TX
  } state_t;

  typedef struct packed {
    logic [3:0]  s1;
    logic [3:0]  s2;
    state_t      st;
    logic        mon;
    logic        blank;
    logic        div_hi;
    logic        sec_need;
    logic        sec_fail;
    logic        sec_ok;
    logic        rst_prev;
    logic        issued;
    logic        go;
    tx_kind_t    kind;
    logic [3:0]  bits;
    logic [2:0]  idx;
    logic [2:0]  cnt;
    logic [7:0]  op;
    logic [7:0]  rxb;
    logic [15:0] addr;
    logic [15:0] ptr;
    logic [7:0]  data;
    logic [7:0]  spl;
    logic        more;
    logic [15:0] maddr;
    logic [7:0]  mwdata;
    logic        mwe;
    logic        mre;
    logic        stack_req;
    logic        run_rq;
    logic        illegal;
    logic [1:0]  bdiv;
    logic        bus_en;
    logic [15:0] vrst;
    logic [15:0] vswi;
  } mon_t;

  mon_t q;
  mon_t n;

  logic [BIT_W-1:0] bit_cycles;
  logic             ser_s;
  logic             divsel_s;
  logic             hv_s;
  logic             ext_s;
  logic             tx_done;
  logic             rx_valid;
  logic             rx_break;
  logic [7:0]       rx_data;
  logic             txs;
  logic             fin;
  logic [7:0]       opn;
  logic [2:0]       need;
  logic [15:0]      sp1;

  // pins from outside the clock domain pass two flops first
  assign ser_s = q.s2[0];
  assign divsel_s = q.s2[1];
  assign hv_s = q.s2[2];
  assign ext_s = q.s2[3];
  assign sp1 = stack_pointer + 16'h0001;

  // oscillator is core_clk; bit period follows the latched select
  assign bit_cycles = q.div_hi ? BIT_W'(DIV_HI_P) : // see [RULE6]
                      BIT_W'(DIV_LO_P);

  mon_serial_phy u_phy (
    .core_clk   (core_clk),
    .rst        (rst),
    .bit_cycles (bit_cycles),
    .rx_pin     (ser_s),
    .tx_go      (q.go),
    .tx_kind    (q.kind),
    .tx_bits    (q.bits),
    .tx_byte    (q.data),
    .tx_out     (monitor_serial_pin_out),
    .tx_oe      (monitor_serial_pin_oe),
    .tx_done    (tx_done),
    .rx_valid   (rx_valid),
    .rx_break   (rx_break),
    .rx_data    (rx_data)
  );

  always_comb
  begin
    n = q;
    n.s1 = {ext_reset_n, entry_voltage_pin_hv, divider_select_pin,
            monitor_serial_pin_in};
    n.s2 = q.s1;
    n.go = 1'b0;
    n.mwe = 1'b0;
    n.mre = 1'b0;
    n.stack_req = 1'b0;
    n.run_rq = 1'b0;
    n.bus_en = 1'b0;
    opn = (q.cnt == '0) ? q.rxb : q.op;
    need = LEN_ONE;
    // bus runs at oscillator/4 or /2, 256 bus cycles per bit
    if (q.bdiv == (q.div_hi ? BUS_LIM_HI : BUS_LIM_LO)) // see [RULE8]
    begin
      n.bdiv = '0;
      n.bus_en = 1'b1;
    end
    else
      n.bdiv = q.bdiv + 1'b1;
    n.vrst = q.mon ? VEC_RST_MON : VEC_RST_USER; // see [RULE2]
    n.vswi = q.mon ? VEC_SWI_MON : VEC_SWI_USER; // see [RULE2]
    n.illegal = cpu_fetch_flash && q.mon && !q.sec_ok; // see [RULE18]
    // shared launch of every bit-engine job; data byte is q.data
    txs = 1'b1;
    unique case (q.st)
      S_RDY_BRK, S_BRK_TX:
      begin
        n.kind = TX_BREAK;
        n.bits = FRAME_BITS;
      end
      S_ECHO, S_DATA_TX:
      begin
        n.kind = TX_BYTE;
        n.bits = FRAME_BITS;
      end
      S_ECHO_GAP, S_DATA_GAP, S_BRK_GAP:
      begin
        n.kind = TX_HIGH; // see [RULE11] [RULE5]
        n.bits = GAP_BITS;
      end
      S_WAIT11:
      begin
        n.kind = TX_WAIT; // see [RULE10]
        n.bits = WAIT_BITS;
      end
      default:
        txs = 1'b0;
    endcase
    if (txs && !q.issued)
    begin
      n.go = 1'b1;
      n.issued = 1'b1;
    end
    fin = txs && q.issued && tx_done;
    if (fin)
      n.issued = 1'b0;
    n.rst_prev = ext_s;
    if (!ext_s)
    begin
      n.st = S_OFF;
      n.issued = 1'b0;
      if (!q.blank)
        n.mon = 1'b0; // see [RULE1]
    end
    else if (!q.rst_prev)
    begin
      // selection taken at the reset release only
      if (!q.blank)
      begin
        n.mon = hv_s || reset_vector_blank; // see [RULE23]
        n.blank = !hv_s && reset_vector_blank;
        n.div_hi = hv_s ? divsel_s : 1'b1; // see [RULE6] [RULE7]
      end
      n.cnt = '0;
      n.idx = '0;
      if (n.mon)
      begin
        n.stack_req = 1'b1; // see [RULE15]
        // security only after power-on; passes survive other resets
        n.st = q.sec_need ? S_SEC_RX : S_RDY_BRK; // see [RULE16] [RULE17]
      end
    end
    else
    begin
      unique case (q.st)
        S_OFF: ;
        S_SEC_RX:
          if (rx_valid)
          begin
            n.rxb = rx_data;
            n.data = rx_data;
            n.st = S_ECHO_GAP;
          end
        S_CMD_RX:
          if (rx_break)
            n.st = S_BRK_GAP; // see [RULE5]
          else if (rx_valid)
          begin
            n.rxb = rx_data;
            n.data = rx_data; // see [RULE9]
            n.st = S_ECHO_GAP;
          end
        S_ECHO_GAP:
          if (fin)
            n.st = S_ECHO;
        S_ECHO:
          if (fin)
          begin
            if (q.sec_need)
            begin
              n.maddr = SEC_BASE + 16'(q.idx); // see [RULE16]
              n.mre = 1'b1;
              n.st = S_SEC_CMP;
            end
            else
              n.st = S_DISPATCH;
          end
        S_SEC_CMP:
          if (!q.issued)
            n.issued = 1'b1;
          else
          begin
            n.issued = 1'b0;
            // erased locations read FF, so FF bytes then match
            n.sec_fail = q.sec_fail || (mem_rdata != q.rxb); // see [RULE21]
            n.idx = q.idx + 1'b1;
            n.st = S_SEC_RX;
            if (q.idx == SEC_LAST)
            begin
              n.sec_need = 1'b0;
              n.st = S_RDY_BRK; // see [RULE19]
              if (!n.sec_fail)
              begin
                n.maddr = SEC_FLAG_ADDR;
                n.mre = 1'b1;
                n.st = S_FLAG_RD;
              end
            end
          end
        S_FLAG_RD:
          if (!q.issued)
            n.issued = 1'b1;
          else
          begin
            n.issued = 1'b0;
            n.mwdata = mem_rdata | SEC_FLAG_MASK; // see [RULE20]
            n.mwe = 1'b1;
            n.sec_ok = 1'b1; // see [RULE17]
            n.st = S_RDY_BRK;
          end
        S_RDY_BRK:
          if (fin)
            n.st = S_CMD_RX;
        S_DISPATCH:
        begin
          unique case (q.cnt)
            3'h0: n.op = q.rxb;
            // indexed write: second byte is data, not an address
            3'h1:
              if (opn == OP_INDEXED_WRITE_CMD)
                n.spl = q.rxb; // see [RULE13]
              else
                n.addr[15:8] = q.rxb;
            3'h2: n.addr[7:0] = q.rxb;
            default: n.spl = q.rxb;
          endcase
          if (opn == OP_READ)
            need = LEN_READ;
          else if (opn == OP_WRITE)
            need = LEN_WRITE;
          else if (opn == OP_INDEXED_WRITE_CMD)
            need = LEN_INDEXED_WRITE_CMD;
          n.cnt = q.cnt + 1'b1;
          n.st = S_CMD_RX;
          if (n.cnt == need)
          begin
            n.cnt = '0;
            n.more = 1'b0;
            if (opn == OP_READ || opn == OP_INDEXED_READ_CMD)
            begin
              n.maddr = (opn == OP_READ) ? n.addr : q.ptr;
              n.mre = 1'b1;
              n.st = S_FETCH;
            end
            else if (opn == OP_STACK_POINTER_READ_CMD)
            begin
              n.data = sp1[15:8]; // see [RULE14]
              n.spl = sp1[7:0];
              n.more = 1'b1;
              n.st = S_DATA_GAP;
            end
            else if (opn == OP_WRITE || opn == OP_INDEXED_WRITE_CMD ||
                     opn == OP_RUN)
              n.st = S_WAIT11; // see [RULE10]
          end
        end
        S_FETCH:
          if (!q.issued)
            n.issued = 1'b1;
          else
          begin
            n.issued = 1'b0;
            n.ptr = q.maddr + 16'h0001; // see [RULE13]
            n.data = (q.maddr >= FLASH_BASE && !q.sec_ok) ?
                     FLASH_INVALID : mem_rdata; // see [RULE18]
            n.st = S_DATA_GAP;
          end
        S_DATA_GAP:
          if (fin)
            n.st = S_DATA_TX; // see [RULE11]
        S_DATA_TX:
          if (fin)
          begin
            n.st = S_WAIT11;
            if (q.more)
            begin
              n.data = q.spl;
              n.more = 1'b0;
              n.st = S_DATA_GAP;
            end
          end
        S_WAIT11:
          if (rx_break)
          begin
            n.issued = 1'b0;
            n.st = S_BRK_GAP; // see [RULE10]
          end
          else if (fin)
            n.st = (q.op == OP_WRITE || q.op == OP_INDEXED_WRITE_CMD ||
                    q.op == OP_RUN) ? S_EXEC : S_CMD_RX;
        S_EXEC:
        begin
          n.st = S_CMD_RX;
          if (q.op == OP_RUN)
            n.run_rq = 1'b1; // see [RULE15]
          else
          begin
            n.maddr = (q.op == OP_WRITE) ? q.addr : q.ptr;
            n.ptr = n.maddr + 16'h0001; // see [RULE13]
            n.mwdata = q.spl;
            n.mwe = 1'b1;
          end
        end
        S_BRK_GAP:
          if (fin)
            n.st = S_BRK_TX; // see [RULE5]
        S_BRK_TX:
          if (fin)
            n.st = S_CMD_RX;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.sec_need <= 1'b1;
      q.div_hi <= 1'b1;
      q.vrst <= VEC_RST_USER;
      q.vswi <= VEC_SWI_USER;
    end
    else
      q <= n;
  end

  assign mem_addr = q.maddr;
  assign mem_wdata = q.mwdata;
  assign mem_we = q.mwe;
  assign mem_re = q.mre;
  assign monitor_mode = q.mon;
  assign security_ok = q.sec_ok;
  assign bus_clk_en = q.bus_en;
  assign vec_reset_addr = q.vrst;
  assign vec_swi_addr = q.vswi;
  assign stack_entry_req = q.stack_req;
  assign run_req = q.run_rq;
  assign illegal_addr_reset = q.illegal;

  AST_VEC_MON: assert property ( // see [RULE2]
    @(posedge core_clk) disable iff (rst)
    q.mon && $past(q.mon) |-> vec_reset_addr == VEC_RST_MON &&
                              vec_swi_addr == VEC_SWI_MON)
    else $error("monitor vectors wrong");
  AST_BLANK_HOLD: assert property ( // see [RULE1]
    @(posedge core_clk) disable iff (rst)
    q.blank && q.mon && !ext_s |=> q.mon)
    else $error("blank-entry monitor left on pin reset");
  AST_BREAK_REPLY: assert property ( // see [RULE5]
    @(posedge core_clk) disable iff (rst)
    q.st == S_CMD_RX && ext_s && q.rst_prev && rx_break
    |=> q.st == S_BRK_GAP)
    else $error("break not answered");
  AST_DIV_FIXED: assert property ( // see [RULE7]
    @(posedge core_clk) disable iff (rst)
    q.blank |-> bit_cycles == BIT_W'(DIV_HI_P))
    else $error("blank entry divider not 1024");
  AST_BUS_DIV4: assert property ( // see [RULE8]
    @(posedge core_clk) disable iff (rst)
    bus_clk_en && q.div_hi && $stable(q.div_hi)
    |=> !bus_clk_en [*3] ##1 bus_clk_en)
    else $error("bus enable not every fourth cycle");
  AST_READY_AFTER_SEC: assert property ( // see [RULE19]
    @(posedge core_clk) disable iff (rst)
    q.st == S_RDY_BRK |-> !q.sec_need)
    else $error("ready break before security bytes");
  AST_SEC_FLAG: assert property ( // see [RULE20]
    @(posedge core_clk) disable iff (rst)
    $rose(security_ok) |-> mem_we && mem_addr == SEC_FLAG_ADDR &&
                           (mem_wdata & SEC_FLAG_MASK) != 8'h00)
    else $error("security flag not written");
  AST_ILLEGAL: assert property ( // see [RULE18]
    @(posedge core_clk) disable iff (rst)
    cpu_fetch_flash && q.mon && !q.sec_ok |=> illegal_addr_reset)
    else $error("no illegal address reset");
  AST_SP_HIGH: assert property ( // see [RULE14]
    @(posedge core_clk) disable iff (rst)
    q.st == S_DISPATCH && q.cnt == 3'h0 && q.rxb == OP_STACK_POINTER_READ_CMD &&
    ext_s && q.rst_prev |=> q.data == $past(sp1[15:8]) &&
                            q.spl == $past(sp1[7:0]))
    else $error("stack pointer read value wrong");
endmodule
`default_nettype wire

// >>> tb/mon_host_model.sv
// host side of the monitor link: sends and receives nrz frames
`timescale 1ns/1ps
`default_nettype none
module mon_host_model
#(
  parameter int BITC = 32
)
(
  input  wire logic core_clk,
  input  wire logic pin,
  output logic      drv,
  output logic      oe
);
  initial
  begin
    drv = 1'b1;
    oe  = 1'b0;
  end

  task automatic hold_bits(input int n);
    repeat (n * BITC) @(posedge core_clk);
  endtask

  // a byte waits one idle bit after the echo; a break goes at once
  // so that it can still land inside the device's turnaround wait
  task automatic send(input logic [7:0] b, input logic brk);
    logic [9:0] f;
    f = brk ? 10'h000 : {1'b1, b, 1'b0};
    if (!brk)
      hold_bits(1);
    for (int i = 0; i < 10; i++)
    begin
      #1 drv = f[i];
      oe = 1'b1;
      hold_bits(1);
    end
    #1 oe = 1'b0;
    drv = 1'b1;
  endtask

  task automatic recv(output logic [7:0] b, output logic brk);
    logic [9:0] f;
    int         n;
    n = 0;
    while (pin !== 1'b0 && n < 16 * BITC)
    begin
      @(posedge core_clk);
      n++;
    end
    repeat (BITC / 2) @(posedge core_clk);
    for (int i = 0; i < 10; i++)
    begin
      f[i] = pin;
      hold_bits(1);
    end
    b   = f[8:1];
    brk = (f === 10'h000);
  endtask
endmodule
`default_nettype wire

// >>> tb/monitor_serial_command_port_tb_top.sv
// top bench for the monitor serial command port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) \
    begin \
      failures++; \
      $display("[ERR] %s exp %h got %h", nm, exp, got); \
    end \
  end
module monitor_serial_command_port_tb_top
  import mon_pkg::*;
;
  localparam int BITC = 32;
  logic        core_clk;
  logic        rst;
  logic        pin;
  logic        host_drv;
  logic        host_oe;
  logic        dev_out;
  logic        dev_oe;
  logic        sel;
  logic        ext_reset_n;
  logic [7:0]  mem_rdata;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic        mon;
  logic        sec_ok;
  logic [15:0] vrst;
  logic [15:0] vswi;
  logic        fetch;
  logic        illegal;
  logic        stack_req;
  logic        run_req;
  logic [7:0]  mem [0:65535];
  int          failures;
  int          num_checks;
  int          cyc;
  int          runs;
  int          stacks;

  // released line is pulled up
  assign pin = dev_oe ? dev_out : (host_oe ? host_drv : 1'b1);

  monitor_serial_command_port #(.DIV_HI_P(BITC), .DIV_LO_P(BITC / 2))
    i_monitor_serial_command_port (
    .core_clk(core_clk), .rst(rst), .monitor_serial_pin_in(pin),
    .monitor_serial_pin_out(dev_out), .monitor_serial_pin_oe(dev_oe),
    .divider_select_pin(sel), .entry_voltage_pin_hv(1'b0),
    .ext_reset_n(ext_reset_n), .reset_vector_blank(1'b1),
    .stack_pointer(16'h01F0), .cpu_fetch_flash(fetch),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_re(), .monitor_mode(mon), .security_ok(sec_ok),
    .bus_clk_en(), .vec_reset_addr(vrst), .vec_swi_addr(vswi),
    .stack_entry_req(stack_req), .run_req(run_req),
    .illegal_addr_reset(illegal));

  mon_host_model #(.BITC(BITC)) i_mon_host_model (
    .core_clk(core_clk), .pin(pin), .drv(host_drv), .oe(host_oe));

  always @(posedge core_clk)
  begin
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem[mem_addr];
    if (run_req)
      runs++;
    if (stack_req)
      stacks++;
    cyc++;
    // the scenarios need roughly 35000 cycles
    if (cyc == 60000)
    begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic xfer(input logic [7:0] b);
    logic [7:0] got;
    logic       brk;
    i_mon_host_model.send(b, 1'b0);
    i_mon_host_model.recv(got, brk);
    `CHK("echo", b, got)
  endtask

  task automatic rx(input logic [7:0] e, input logic eb);
    logic [7:0] got;
    logic       brk;
    i_mon_host_model.recv(got, brk);
    `CHK("rx", {eb, eb ? 8'h00 : e}, {brk, eb ? 8'h00 : got})
  endtask

  // one flash fetch cycle, then the reset request is looked at
  task automatic fetch_chk(input logic e);
    #1 fetch = 1'b1;
    @(posedge core_clk);
    #1 fetch = 1'b0;
    `CHK("illegal", e, illegal)
  endtask

  task automatic por();
    #1 rst = 1'b1;
    repeat (16) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge core_clk);
    `CHK("mode", 1'b1, mon)
  endtask

  // wrong code: flash reads invalid, then power-on reset before retrying
  task automatic t_bad_sec();
    for (int i = 0; i < 8; i++)
      xfer(8'h00);
    rx(8'h00, 1'b1);
    `CHK("badsec", 1'b0, sec_ok)
    `CHK("noflag", 8'h00, mem[16'h0060] & SEC_FLAG_MASK)
    fetch_chk(1'b1);
    xfer(OP_READ);
    xfer(8'hFF);
    xfer(8'hF6);
    rx(FLASH_INVALID, 1'b0);
    i_mon_host_model.hold_bits(12);
    por();
    $display("test bad security done");
  endtask

  task automatic t_security();
    for (int i = 0; i < 8; i++)
      xfer(mem[SEC_BASE + 16'(i)]);
    rx(8'h00, 1'b1);
    `CHK("sec", 1'b1, sec_ok)
    `CHK("flag", SEC_FLAG_MASK, mem[16'h0060] & SEC_FLAG_MASK)
    `CHK("vec", {VEC_RST_MON, VEC_SWI_MON}, {vrst, vswi})
    fetch_chk(1'b0);
    $display("test security done");
  endtask

  task automatic t_access();
    xfer(OP_READ);
    xfer(8'hFF);
    xfer(8'hF8);
    rx(8'h33, 1'b0);
    i_mon_host_model.hold_bits(12);
    xfer(OP_INDEXED_READ_CMD);
    rx(8'h44, 1'b0);
    i_mon_host_model.hold_bits(12);
    xfer(OP_WRITE);
    xfer(8'h00);
    xfer(8'h80);
    xfer(8'h5A);
    i_mon_host_model.hold_bits(12);
    xfer(OP_INDEXED_WRITE_CMD);
    xfer(8'hA5);
    i_mon_host_model.hold_bits(12);
    `CHK("wr", 16'h5AA5, {mem[16'h0080], mem[16'h0081]})
    xfer(OP_STACK_POINTER_READ_CMD);
    rx(8'h01, 1'b0);
    rx(8'hF1, 1'b0);
    i_mon_host_model.hold_bits(12);
    xfer(OP_RUN);
    i_mon_host_model.hold_bits(12);
    `CHK("run", 1, runs)
    $display("test access done");
  endtask

  // break in, gap and break back; a break in the turnaround wait drops
  // the pending write; then external reset keeps monitor mode
  task automatic t_break_reset();
    i_mon_host_model.hold_bits(12);
    i_mon_host_model.send(8'h00, 1'b1);
    rx(8'h00, 1'b1);
    xfer(OP_WRITE);
    xfer(8'h00);
    xfer(8'h90);
    xfer(8'h77);
    i_mon_host_model.send(8'h00, 1'b1);
    rx(8'h00, 1'b1);
    `CHK("cancel", 8'h00, mem[16'h0090])
    #1 ext_reset_n = 1'b0;
    repeat (8) @(posedge core_clk);
    #1 ext_reset_n = 1'b1;
    rx(8'h00, 1'b1);
    `CHK("stay", 2'h3, {mon, sec_ok})
    `CHK("stack", 3, stacks)
    $display("test break reset done");
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem[i] = 8'h00;
    for (int i = 0; i < 8; i++)
      mem[SEC_BASE + 16'(i)] = 8'(8'h11 * (i + 1));
    // select low must not halve the bit time on blank-vector entry
    sel = 1'b0;
    fetch = 1'b0;
    ext_reset_n = 1'b1;
    rst = 1'b1;
    por();
    t_bad_sec();
    t_security();
    t_access();
    t_break_reset();
    end_of_test();
  end
endmodule
`default_nettype wire
